// file: rx_flow_sel_regs.vh
// Register map, field layout and size constants for the receive flow queue selector.
`ifndef RX_FLOW_SEL_REGS_VH
`define RX_FLOW_SEL_REGS_VH

// ****************************************************************
// Flow table geometry
// ****************************************************************
`define NUM_FLOWS           8
`define FLOW_IDX_W          3
`define FLOW_STRIDE_SHIFT   5
`define ADDR_W              12
`define FLOW_LAST           3'h7

// ****************************************************************
// Register offsets within a flow (byte addresses)
// ****************************************************************
`define OFS_FIRST_SECOND    5'h0C
`define OFS_THIRD_FOURTH    5'h10
`define OFS_THRESH_LOW      5'h14
`define OFS_THRESH_HIGH     5'h18
`define OFS_SIZE3_SEL       5'h1C
`define OFS_THRESH_EN       5'h08

// ****************************************************************
// Field layout of the queue selection words
// ****************************************************************
`define SEL_MASK            32'h3FFF_3FFF
`define HI_MGR_MSB          29
`define HI_MGR_LSB          28
`define HI_Q_MSB            27
`define HI_Q_LSB            16
`define LO_MGR_MSB          13
`define LO_MGR_LSB          12
`define LO_Q_MSB            11
`define LO_Q_LSB            0
`define TH_HI_MSB           31
`define TH_HI_LSB           16
`define TH_LO_MSB           15
`define TH_LO_LSB           0
`define TH_EN_MASK          32'h0000_0007

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define MGR_W               2
`define QNUM_W              12
`define SIZE_W              21
`define TH_SHIFT            5
`define REG_RESET           32'h0000_0000
`define BUF_IDX_W           2
`define BUF_FIRST           2'h0
`define BUF_SECOND          2'h1
`define BUF_THIRD           2'h2
`define BUF_LATER           2'h3

`endif

// file: first_buf_picker.v
// Size-threshold selection of the first packet buffer queue.
`timescale 1ns/100ps
`default_nettype none
`include "rx_flow_sel_regs.vh"

module first_buf_picker (
  // Packet size and threshold enables
  input  wire [`SIZE_W-1:0]  i_pkt_size,
  input  wire [2:0]          i_th_en,
  input  wire [15:0]         i_size_limit_0,
  input  wire [15:0]         i_size_limit_1,
  input  wire [15:0]         i_size_limit_2,
  // Result: size index 0..3
  output reg  [1:0]          o_size_idx
);

  function le_limit;
    input [`SIZE_W-1:0] size;
    input [15:0]        lim;
    begin
      le_limit = ({{`TH_SHIFT{1'b0}}, size} <= {lim, {`TH_SHIFT{1'b0}}});
    end
  endfunction

  always @* begin
    o_size_idx = 2'h0;
    if (!i_th_en[0]) begin
      o_size_idx = 2'h0;
    end else if (le_limit(i_pkt_size, i_size_limit_0)) begin
      o_size_idx = 2'h0;
    end else if (!i_th_en[1]) begin
      o_size_idx = 2'h1;
    end else if (le_limit(i_pkt_size, i_size_limit_1)) begin
      o_size_idx = 2'h1;
    end else if (!i_th_en[2]) begin
      o_size_idx = 2'h2;
    end else if (le_limit(i_pkt_size, i_size_limit_2)) begin
      o_size_idx = 2'h2;
    end else begin
      o_size_idx = 2'h3;
    end
  end

endmodule // first_buf_picker
`default_nettype wire

// file: rx_flow_free_queue_select.v
// Per-flow receive configuration words and free descriptor queue selection.
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "rx_flow_sel_regs.vh"

module rx_flow_free_queue_select #(
  parameter HAS_THRESH = 1
) (
  // Clock, reset, enable
  input  wire                   i_clk,
  input  wire                   i_resetn,
  input  wire                   i_ce,
  // Register port
  input  wire [`ADDR_W-1:0]     i_addr,
  input  wire [31:0]            i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [31:0]            o_rdata,
  // Allocation request
  input  wire                   i_req,
  input  wire [`FLOW_IDX_W-1:0] i_flow,
  input  wire [`BUF_IDX_W-1:0]  i_buf_idx,
  input  wire                   i_host_type,
  input  wire [`SIZE_W-1:0]     i_pkt_size,
  // Selected free descriptor queue
  output reg                    o_sel_valid,
  output reg  [`MGR_W-1:0]      o_sel_mgr,
  output reg  [`QNUM_W-1:0]     o_sel_queue
);

  // ****************************************************************
  // Per-flow storage
  // ****************************************************************
  reg [31:0] first_second_ff [0:`NUM_FLOWS-1];
  reg [31:0] third_fourth_ff [0:`NUM_FLOWS-1];
  reg [31:0] thresh_low_ff   [0:`NUM_FLOWS-1];
  reg [31:0] thresh_high_ff  [0:`NUM_FLOWS-1];
  reg [31:0] size3_sel_ff    [0:`NUM_FLOWS-1];
  reg [31:0] thresh_en_ff    [0:`NUM_FLOWS-1];

  wire [`FLOW_IDX_W-1:0] wr_flow = i_addr[`FLOW_STRIDE_SHIFT+`FLOW_IDX_W-1:`FLOW_STRIDE_SHIFT];
  wire [4:0]             wr_ofs  = i_addr[`FLOW_STRIDE_SHIFT-1:0];
  wire                   in_map  = (i_addr[`ADDR_W-1:`FLOW_STRIDE_SHIFT+`FLOW_IDX_W] == 4'h0);
  wire [31:0]            th_mask = (HAS_THRESH != 0) ? 32'hFFFF_FFFF : `REG_RESET;
  wire [31:0]            en_mask = (HAS_THRESH != 0) ? `TH_EN_MASK : `REG_RESET;

  integer k;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (k = 0; k < `NUM_FLOWS; k = k + 1) begin
        first_second_ff[k] <= `REG_RESET;
        third_fourth_ff[k] <= `REG_RESET;
        thresh_low_ff[k]   <= `REG_RESET;
        thresh_high_ff[k]  <= `REG_RESET;
        size3_sel_ff[k]    <= `REG_RESET;
        thresh_en_ff[k]    <= `REG_RESET;
      end
    end else if (i_ce && i_wr && in_map) begin
      case (wr_ofs)
        `OFS_FIRST_SECOND: first_second_ff[wr_flow] <= i_wdata & `SEL_MASK;
        `OFS_THIRD_FOURTH: third_fourth_ff[wr_flow] <= i_wdata & `SEL_MASK;
        `OFS_THRESH_LOW:   thresh_low_ff[wr_flow]   <= i_wdata & th_mask;
        `OFS_THRESH_HIGH:  thresh_high_ff[wr_flow]  <= i_wdata & th_mask & `SEL_MASK;
        `OFS_SIZE3_SEL:    size3_sel_ff[wr_flow]    <= i_wdata & th_mask & `SEL_MASK;
        `OFS_THRESH_EN:    thresh_en_ff[wr_flow]    <= i_wdata & en_mask;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Threshold and size-3 words are write-only; only the first/second and third/fourth selection words and the enable read back.
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `REG_RESET;
    end else if (i_ce) begin
      o_rdata <= `REG_RESET;
      if (i_rd && in_map) begin
        case (wr_ofs)
          `OFS_FIRST_SECOND: o_rdata <= first_second_ff[wr_flow];
          `OFS_THIRD_FOURTH: o_rdata <= third_fourth_ff[wr_flow];
          `OFS_THRESH_EN:    o_rdata <= thresh_en_ff[wr_flow];
          default:           o_rdata <= `REG_RESET;
        endcase
      end
    end
  end

  // ****************************************************************
  // Queue selection
  // ****************************************************************
  wire [31:0] w_d  = first_second_ff[i_flow];
  wire [31:0] w_e  = third_fourth_ff[i_flow];
  wire [31:0] w_f  = thresh_low_ff[i_flow];
  wire [31:0] w_g  = thresh_high_ff[i_flow];
  wire [31:0] w_h  = size3_sel_ff[i_flow];
  wire [1:0]  size_idx;

  first_buf_picker u_picker (
    .i_pkt_size     (i_pkt_size),
    .i_th_en        (thresh_en_ff[i_flow][2:0]),
    .i_size_limit_0 (w_f[`TH_HI_MSB:`TH_HI_LSB]),
    .i_size_limit_1 (w_f[`TH_LO_MSB:`TH_LO_LSB]),
    .i_size_limit_2 (w_g[`TH_HI_MSB:`TH_HI_LSB]),
    .o_size_idx     (size_idx)
  );

  reg [31:0] nxt_word;
  reg        nxt_high;

  always @* begin
    nxt_word = w_d;
    nxt_high = 1'b1;
    case (i_buf_idx)
      `BUF_FIRST: begin
        case (size_idx)
          2'h0: begin nxt_word = w_d; nxt_high = 1'b1; end
          2'h1: begin nxt_word = w_g; nxt_high = 1'b0; end
          2'h2: begin nxt_word = w_h; nxt_high = 1'b1; end
          default: begin nxt_word = w_h; nxt_high = 1'b0; end
        endcase
      end
      `BUF_SECOND: begin nxt_word = w_d; nxt_high = 1'b0; end
      `BUF_THIRD:  begin nxt_word = w_e; nxt_high = 1'b1; end
      default:     begin nxt_word = w_e; nxt_high = 1'b0; end
    endcase
    // Non-host packets take the size-0 first-buffer queue for every buffer after the first.
    if (!i_host_type && i_buf_idx != `BUF_FIRST) begin
      nxt_word = w_d;
      nxt_high = 1'b1;
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sel_valid <= 1'b0;
      o_sel_mgr   <= 2'h0;
      o_sel_queue <= 12'h000;
    end else if (i_ce) begin
      o_sel_valid <= i_req;
      if (i_req) begin
        if (nxt_high) begin
          o_sel_mgr   <= nxt_word[`HI_MGR_MSB:`HI_MGR_LSB];
          o_sel_queue <= nxt_word[`HI_Q_MSB:`HI_Q_LSB];
        end else begin
          o_sel_mgr   <= nxt_word[`LO_MGR_MSB:`LO_MGR_LSB];
          o_sel_queue <= nxt_word[`LO_Q_MSB:`LO_Q_LSB];
        end
      end
    end
  end

endmodule // rx_flow_free_queue_select
`default_nettype wire

// file: rx_flow_sel_checker.sv
// Port checker for the flow queue selector.
`timescale 1ns/100ps
`default_nettype none
`include "rx_flow_sel_regs.vh"
module rx_flow_sel_checker (
  input wire logic                i_clk,
  input wire logic                i_resetn,
  input wire logic                i_ce,
  input wire logic [`ADDR_W-1:0]  i_addr,
  input wire logic                i_rd,
  input wire logic                i_req,
  input wire logic [31:0]         o_rdata,
  input wire logic                o_sel_valid,
  input wire logic [`MGR_W-1:0]   o_sel_mgr,
  input wire logic [`QNUM_W-1:0]  o_sel_queue
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_valid_after_req: assert property (i_ce && i_req |=> o_sel_valid)
    else $error("no valid after request");
  a_valid_only_req: assert property (i_ce && !i_req |=> !o_sel_valid)
    else $error("valid without request");
  a_sel_holds: assert property (i_ce && !i_req |=> $stable(o_sel_mgr) && $stable(o_sel_queue))
    else $error("selection moved without request");
  a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_reserved_zero: assert property (i_ce && i_rd |=> (o_rdata & 32'hC000_C000) == 32'h0)
    else $error("reserved bits read nonzero");
  a_limits_wo: assert property (i_ce && i_rd && i_addr[4:0] == 5'h14 |=> o_rdata == 32'h0)
    else $error("threshold word readable");
  a_unmapped_zero: assert property (i_ce && i_rd && i_addr[11:8] != 4'h0 |=> o_rdata == 32'h0)
    else $error("unmapped read nonzero");
  // Reset must quiet the outputs, so this one is not disabled by it.
  a_reset_quiet: assert property (disable iff (1'b0) !i_resetn |-> !o_sel_valid && o_rdata == 32'h0)
    else $error("outputs active in reset");
  c_req: cover property (i_ce && i_req);
  c_rd_limits: cover property (i_rd && i_addr[4:0] == 5'h14);
  c_sel_mgr: cover property (o_sel_valid && o_sel_mgr != 2'h0);
endmodule // rx_flow_sel_checker
bind rx_flow_free_queue_select rx_flow_sel_checker rx_flow_sel_checker_inst (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr), .i_rd(i_rd),
  .i_req(i_req), .o_rdata(o_rdata), .o_sel_valid(o_sel_valid),
  .o_sel_mgr(o_sel_mgr), .o_sel_queue(o_sel_queue));
`default_nettype wire

// file: rx_flow_sel_partner.sv
// Back-end model that issues buffer allocation requests.
`timescale 1ns/100ps
`default_nettype none
module rx_flow_sel_partner (
  input wire logic        i_clk,
  input wire logic        i_sel_valid,
  input wire logic [1:0]  i_sel_mgr,
  input wire logic [11:0] i_sel_queue,
  output var logic        o_req,
  output var logic [2:0]  o_flow,
  output var logic [1:0]  o_buf_idx,
  output var logic        o_host_type,
  output var logic [20:0] o_pkt_size
);
  initial begin
    o_req = 1'b0;
    o_flow = 3'h0;
    o_buf_idx = 2'h0;
    o_host_type = 1'b0;
    o_pkt_size = 21'h0;
  end
  task automatic alloc(input logic [2:0] f, input logic [1:0] b, input logic h,
                       input logic [20:0] s, output logic [14:0] r);
    @(posedge i_clk);
    o_req <= 1'b1;
    o_flow <= f;
    o_buf_idx <= b;
    o_host_type <= h;
    o_pkt_size <= s;
    @(posedge i_clk);
    o_req <= 1'b0;
    // The size is no longer valid once taken, so show something else.
    o_pkt_size <= ~s;
    #1;
    r = {i_sel_valid, i_sel_mgr, i_sel_queue};
  endtask
endmodule // rx_flow_sel_partner
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the flow queue selector.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        i_clk, i_resetn, i_ce, i_wr, i_rd, i_req, i_host_type, o_sel_valid;
  logic [11:0] i_addr, o_sel_queue;
  logic [31:0] i_wdata, o_rdata;
  logic [2:0]  i_flow;
  logic [1:0]  i_buf_idx, o_sel_mgr;
  logic [20:0] i_pkt_size;
  int          miscompares = 0;
  int          n_tests = 0;
  rx_flow_free_queue_select rx_flow_free_queue_select_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_req(i_req), .i_flow(i_flow),
    .i_buf_idx(i_buf_idx), .i_host_type(i_host_type), .i_pkt_size(i_pkt_size),
    .o_sel_valid(o_sel_valid), .o_sel_mgr(o_sel_mgr), .o_sel_queue(o_sel_queue));
  rx_flow_sel_partner rx_flow_sel_partner_inst (
    .i_clk(i_clk), .i_sel_valid(o_sel_valid), .i_sel_mgr(o_sel_mgr),
    .i_sel_queue(o_sel_queue), .o_req(i_req), .o_flow(i_flow), .o_buf_idx(i_buf_idx),
    .o_host_type(i_host_type), .o_pkt_size(i_pkt_size));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    cmp(o_rdata, e);
  endtask
  task automatic chk_sel(input logic [1:0] b, input logic [20:0] s, input logic [14:0] e);
    logic [14:0] r;
    rx_flow_sel_partner_inst.alloc(3'h1, b, 1'b1, s, r);
    cmp({17'h0, r}, {17'h0, e});
  endtask
  task automatic t_regs();
    chk_rd(12'h0EC, 32'h0);
    wr(12'h0EC, 32'hFFFF_FFFF);
    chk_rd(12'h0EC, 32'h3FFF_3FFF);
    wr(12'h0F0, 32'hFFFF_FFFF);
    chk_rd(12'h0F0, 32'h3FFF_3FFF);
    wr(12'h0F4, 32'h1234_5678);
    chk_rd(12'h0F4, 32'h0);
    wr(12'h10C, 32'h1111_1111);
    chk_rd(12'h10C, 32'h0);
    chk_rd(12'h00C, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_host();
    // flow words set before any traffic
    wr(12'h02C, 32'h1123_2456);
    wr(12'h030, 32'h3789_1ABC);
    chk_sel(2'h0, 21'h1F_FFFF, 15'h5123);
    chk_sel(2'h1, 21'h40, 15'h6456);
    chk_sel(2'h2, 21'h40, 15'h7789);
    chk_sel(2'h3, 21'h40, 15'h5ABC);
    $display("t_host done");
  endtask
  task automatic t_thresh();
    // limits ascending: 64, 128, 192 bytes
    wr(12'h034, 32'h0002_0004);
    wr(12'h038, 32'h0006_2055);
    wr(12'h03C, 32'h30AA_00BB);
    wr(12'h028, 32'h1);
    chk_sel(2'h0, 21'h40, 15'h5123);
    chk_sel(2'h0, 21'h41, 15'h6055);
    wr(12'h028, 32'h3);
    chk_sel(2'h0, 21'h80, 15'h6055);
    chk_sel(2'h0, 21'h81, 15'h70AA);
    wr(12'h028, 32'h7);
    chk_sel(2'h0, 21'hC0, 15'h70AA);
    chk_sel(2'h0, 21'hC1, 15'h40BB);
    $display("t_thresh done");
  endtask
  task automatic t_nonhost();
    logic [14:0] r;
    // Non-host later buffers fall back to the size-0 first-buffer queue.
    rx_flow_sel_partner_inst.alloc(3'h1, 2'h2, 1'b0, 21'hC1, r);
    cmp({17'h0, r}, {17'h0, 15'h5123});
    $display("t_nonhost done");
  endtask
  task automatic t_freeze();
    logic [14:0] r;
    @(posedge i_clk);
    i_ce <= 1'b0;
    // With the enable low the request is ignored and the old selection stays.
    rx_flow_sel_partner_inst.alloc(3'h1, 2'h1, 1'b1, 21'h40, r);
    cmp({17'h0, r}, {17'h0, 15'h1123});
    @(posedge i_clk);
    i_ce <= 1'b1;
    $display("t_freeze done");
  endtask
  initial begin
    i_resetn = 1'b0;
    i_ce = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h0;
    i_wdata = 32'h0;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_regs();
    t_host();
    t_thresh();
    t_nonhost();
    t_freeze();
    print_verdict();
  end
  // The tests need under a hundred cycles; this allows far more.
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
